//--- include/pbi_pkg.sv
`default_nettype none

package pbi_pkg;

    // Bus commands recognised by the target
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] CMD_MEM_WR  = 4'h7;

    // Decoded memory window: upper address bits compared against a base
    localparam int         WIN_LSB  = 12;
    localparam logic [19:0] WIN_BASE = 20'h000C0;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

    // Clock-run request: one less than the clocks held low before the one-clock high release
    localparam logic [1:0] CKR_LOW_CYC = 2'h1;
    localparam logic [1:0] CKR_ZERO    = 2'h0;
    localparam logic [1:0] CKR_DEC     = 2'h1;

    // Open-drain pins only ever drive low
    localparam logic OD_LOW = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACT  = 2'b01,
        ST_TURN = 2'b11,
        ST_BUSY = 2'b10
    } pbi_state_e;

    // One posted write word with its address and active-low byte enables
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be_n;
    } pbi_wr_s;

    typedef struct packed {
        pbi_state_e    st;
        logic [3:0]    cmd;
        logic [31:0]   addr;
        logic          ap_par;
        logic          ap_chk;
        logic          dp_par;
        logic          dp_chk;
        logic [31:0]   ad;
        logic          ad_oe;
        logic          par;
        logic          par_oe;
        logic          trdy_n;
        logic          trdy_oe;
        logic          devsel_n;
        logic          devsel_oe;
        logic          perr_n;
        logic          perr_oe;
        logic          serr_oe;
        logic          ckr_n;
        logic          ckr_oe;
        logic [1:0]    ckr_cnt;
        logic          ckr_stat;
        logic          rd_req;
        logic [1:0]    vld;
        pbi_wr_s [1:0] buff;
    } pbi_state_s;

    localparam pbi_state_s PBI_STATE_RST = '{
        st:       ST_IDLE,
        trdy_n:   1'b1,
        devsel_n: 1'b1,
        perr_n:   1'b1,
        ckr_n:    1'b1,
        default:  '0
    };

endpackage

`default_nettype wire

//--- rtl/pbi_target.sv
// Overview of operation
// RL1 - Sample every bus signal on rising clock
// RL2 - Pull clock-run low to restart clock
// RL3 - Reset returns all state to defaults
// RL4 - Float every output while reset held
// RL5 - Command in address phase, enables after
// RL6 - Byte enables qualify each data lane
// RL7 - Even parity over AD, C/BE, PAR
// RL8 - Address parity valid next clock
// RL9 - Data parity one clock after ready
// RL10 - Master drives writes, target drives reads
// RL11 - Frame starts and holds the transaction
// RL12 - Frame high marks the final phase
// RL13 - Phase completes when both readies low
// RL14 - Target ready means read data valid
// RL15 - Initiator ready means write data valid
// RL16 - Wait until both readies asserted together
// RL17 - One owner per shared tristate line
// RL18 - Drive high one clock before floating
// RL19 - Wait one clock before taking line
// RL20 - Address and data share one bus
// RL21 - Parity error low on bad write data
// RL22 - System error one clock on address error
// RL23 - Device select on decoded own address
`default_nettype none

module pbi_target
    import pbi_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic [31:0] ad_i,
    output logic      [31:0] ad_o,
    output logic             ad_oe_o,
    input  wire logic [3:0]  cbe_n_i,
    input  wire logic        par_i,
    output logic             par_o,
    output logic             par_oe_o,
    input  wire logic        frame_n_i,
    input  wire logic        irdy_n_i,
    output logic             trdy_n_o,
    output logic             trdy_oe_o,
    output logic             devsel_n_o,
    output logic             devsel_oe_o,
    output logic             perr_n_o,
    output logic             perr_oe_o,
    output logic             serr_n_o,
    output logic             serr_oe_o,
    input  wire logic        clkrun_n_i,
    output logic             clkrun_n_o,
    output logic             clkrun_oe_o,
    output logic             clk_stop_o,
    input  wire logic        clk_req_i,
    input  wire logic        sec_addr_perr_i,
    output logic             rd_req_o,
    output logic      [31:0] rd_addr_o,
    input  wire logic        rd_valid_i,
    input  wire logic [31:0] rd_data_i,
    output logic             wr_valid_o,
    output pbi_wr_s          wr_data_o,
    input  wire logic        wr_ready_i
);

    pbi_state_s s_r;
    pbi_state_s s_nxt;
    logic       xfer;
    logic       is_wr;
    logic       is_rd;
    logic       hit;
    pbi_wr_s    ent;

    // Completed data phase and decode of a fresh address phase
    assign xfer  = s_r.trdy_oe && !s_r.trdy_n && !irdy_n_i; // RL13 RL16
    assign is_wr = (s_r.cmd == CMD_MEM_WR);
    assign is_rd = (s_r.cmd == CMD_MEM_RD);
    assign hit   = (ad_i[31:WIN_LSB] == WIN_BASE) // RL20
                   && ((cbe_n_i == CMD_MEM_RD) || (cbe_n_i == CMD_MEM_WR)); // RL5
    assign ent   = '{addr: s_r.addr, data: ad_i, be_n: cbe_n_i}; // RL6 RL15

    // Next-state logic for the whole target
    always_comb begin
        s_nxt         = s_r;
        s_nxt.ap_chk  = 1'b0;
        s_nxt.dp_chk  = 1'b0;
        s_nxt.ckr_stat = clkrun_n_i; // RL2

        // Drain the head entry; shifting keeps the head a plain flop
        if (s_r.vld[0] && wr_ready_i) begin
            s_nxt.buff[0] = s_r.buff[1];
            s_nxt.vld     = {1'b0, s_r.vld[1]};
        end

        // Accept a write word into the first free slot
        if (xfer && is_wr) begin
            if (!s_nxt.vld[0]) begin
                s_nxt.buff[0] = ent;
                s_nxt.vld[0]  = 1'b1;
            end else begin
                s_nxt.buff[1] = ent;
                s_nxt.vld[1]  = 1'b1;
            end
            s_nxt.dp_par = ^{ad_i, cbe_n_i}; // RL7
            s_nxt.dp_chk = (s_r.cmd != CMD_SPECIAL); // RL21
        end
        if (xfer) begin
            s_nxt.addr = s_r.addr + ADDR_STEP;
        end

        // Read parity follows the driven data by one clock
        s_nxt.par    = ^{s_r.ad, cbe_n_i}; // RL7 RL9
        s_nxt.par_oe = s_r.ad_oe; // RL10

        // Address parity checked against PAR one clock later
        s_nxt.serr_oe = ((s_r.ap_chk && (s_r.ap_par != par_i)) || sec_addr_perr_i)
                        && !s_r.serr_oe; // RL8 RL22

        // Parity error: low one clock, high one clock, then float
        if (s_r.dp_chk && (s_r.dp_par != par_i)) begin
            s_nxt.perr_n  = 1'b0; // RL21
            s_nxt.perr_oe = 1'b1;
        end else if (s_r.perr_oe && !s_r.perr_n) begin
            s_nxt.perr_n = 1'b1; // RL18
        end else begin
            s_nxt.perr_oe = 1'b0;
        end

        // Clock-run request: drive low, drive high, release
        if (s_r.ckr_oe) begin
            if (!s_r.ckr_n) begin
                if (s_r.ckr_cnt == CKR_ZERO) begin
                    s_nxt.ckr_n = 1'b1; // RL18
                end else begin
                    s_nxt.ckr_cnt = s_r.ckr_cnt - CKR_DEC;
                end
            end else begin
                s_nxt.ckr_oe = 1'b0;
            end
        end else if (clkrun_n_i && (clk_req_i || s_r.st != ST_IDLE)) begin
            s_nxt.ckr_oe  = 1'b1; // RL2
            s_nxt.ckr_n   = 1'b0;
            s_nxt.ckr_cnt = CKR_LOW_CYC;
        end

        case (s_r.st)
            ST_IDLE: begin
                // Frame low here is always a fresh address phase
                if (!frame_n_i) begin // RL11
                    s_nxt.cmd    = cbe_n_i; // RL5
                    s_nxt.addr   = ad_i;
                    s_nxt.ap_par = ^{ad_i, cbe_n_i};
                    s_nxt.ap_chk = 1'b1;
                    if (hit) begin
                        s_nxt.st        = ST_ACT;
                        s_nxt.devsel_oe = 1'b1;
                        s_nxt.devsel_n  = 1'b0; // RL23
                        s_nxt.trdy_oe   = 1'b1;
                        s_nxt.trdy_n    = (cbe_n_i == CMD_MEM_WR) ? s_nxt.vld[1] : 1'b1;
                        s_nxt.rd_req    = (cbe_n_i == CMD_MEM_RD);
                    end else begin
                        s_nxt.st = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                // Someone else's transaction; wait for a fully idle bus
                if (frame_n_i && irdy_n_i) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_ACT: begin
                if (is_wr) begin
                    s_nxt.trdy_n = s_nxt.vld[1]; // RL16
                end
                if (is_rd && s_r.rd_req && rd_valid_i) begin
                    s_nxt.rd_req = 1'b0;
                    s_nxt.ad     = rd_data_i;
                    s_nxt.ad_oe  = 1'b1; // RL19
                    s_nxt.trdy_n = 1'b0; // RL14
                end
                if (xfer) begin
                    if (frame_n_i) begin // RL12
                        s_nxt.st       = ST_TURN;
                        s_nxt.devsel_n = 1'b1; // RL18
                        s_nxt.trdy_n   = 1'b1;
                        s_nxt.ad_oe    = 1'b0;
                        s_nxt.rd_req   = 1'b0;
                    end else if (is_rd) begin
                        s_nxt.trdy_n = 1'b1;
                        s_nxt.rd_req = 1'b1;
                    end
                end
            end
            ST_TURN: begin
                s_nxt.trdy_oe   = 1'b0; // RL17
                s_nxt.devsel_oe = 1'b0;
                s_nxt.st        = frame_n_i ? ST_IDLE : ST_BUSY;
            end
            default: begin
                s_nxt = PBI_STATE_RST;
            end
        endcase
    end

    // Single state register; reset floats every pin
    always_ff @(posedge clock_i or negedge nrst_i) begin // RL1
        if (!nrst_i) begin
            s_r <= PBI_STATE_RST; // RL3 RL4
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register, except the constant serr_n_o
    assign ad_o        = s_r.ad;
    assign ad_oe_o     = s_r.ad_oe;
    assign par_o       = s_r.par;
    assign par_oe_o    = s_r.par_oe;
    assign trdy_n_o    = s_r.trdy_n;
    assign trdy_oe_o   = s_r.trdy_oe;
    assign devsel_n_o  = s_r.devsel_n;
    assign devsel_oe_o = s_r.devsel_oe;
    assign perr_n_o    = s_r.perr_n;
    assign perr_oe_o   = s_r.perr_oe;
    assign serr_n_o    = OD_LOW; // Open drain: only the enable moves
    assign serr_oe_o   = s_r.serr_oe;
    assign clkrun_n_o  = s_r.ckr_n;
    assign clkrun_oe_o = s_r.ckr_oe;
    assign clk_stop_o  = s_r.ckr_stat;
    assign rd_req_o    = s_r.rd_req;
    assign rd_addr_o   = s_r.addr;
    assign wr_valid_o  = s_r.vld[0];
    assign wr_data_o   = s_r.buff[0];

    // Checks run on the bus clock and rest during reset
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    property p_devsel_hit;
        (s_r.st == ST_IDLE) && !frame_n_i && hit |=> devsel_oe_o && !devsel_n_o;
    endproperty
    a_devsel_hit: assert property (p_devsel_hit) // RL23
        else $error("device select missing after own address");

    property p_serr_pulse;
        serr_oe_o |=> !serr_oe_o;
    endproperty
    a_serr_pulse: assert property (p_serr_pulse) // RL22
        else $error("system error held longer than one clock");

    property p_serr_cause;
        (s_r.ap_chk && (s_r.ap_par != par_i) && !serr_oe_o) |=> serr_oe_o;
    endproperty
    a_serr_cause: assert property (p_serr_cause) // RL8
        else $error("address parity error not reported");

    property p_par_read;
        $past(ad_oe_o) |-> par_oe_o && (par_o == ^{$past(ad_o), $past(cbe_n_i)});
    endproperty
    a_par_read: assert property (p_par_read) // RL7
        else $error("read parity wrong or late");

    property p_trdy_release;
        $fell(trdy_oe_o) |-> $past(trdy_n_o, 1) && $past(trdy_oe_o, 1);
    endproperty
    a_trdy_release: assert property (p_trdy_release) // RL18
        else $error("target ready floated without high drive");

    property p_read_data;
        trdy_oe_o && !trdy_n_o && is_rd |-> ad_oe_o;
    endproperty
    a_read_data: assert property (p_read_data) // RL14
        else $error("target ready on read without data");

    property p_turnaround;
        (s_r.st == ST_IDLE) && !frame_n_i |=> !ad_oe_o;
    endproperty
    a_turnaround: assert property (p_turnaround) // RL19
        else $error("address bus driven in turnaround clock");

    property p_wr_push;
        xfer && is_wr |=> wr_valid_o;
    endproperty
    a_wr_push: assert property (p_wr_push) // RL13
        else $error("completed write word lost");

    property p_wr_space;
        trdy_oe_o && !trdy_n_o && is_wr |-> !s_r.vld[1];
    endproperty
    a_wr_space: assert property (p_wr_space) // RL16
        else $error("target ready with full write buffer");

    property p_perr_seq;
        $fell(perr_n_o) |=> perr_oe_o && perr_n_o ##1 !perr_oe_o || !perr_n_o;
    endproperty
    a_perr_seq: assert property (p_perr_seq) // RL21
        else $error("parity error release sequence broken");

    property p_clkrun;
        $rose(clkrun_oe_o) |-> !clkrun_n_o ##2 clkrun_n_o && clkrun_oe_o ##1 !clkrun_oe_o;
    endproperty
    a_clkrun: assert property (p_clkrun) // RL2
        else $error("clock-run request shape wrong");

    // Ready is only ever shown by a selected target
    property p_trdy_sel;
        trdy_oe_o && !trdy_n_o |-> devsel_oe_o && !devsel_n_o;
    endproperty
    a_trdy_sel: assert property (p_trdy_sel) // RL23
        else $error("target ready without device select");

    property p_devsel_release;
        $fell(devsel_oe_o) |-> $past(devsel_n_o) && $past(devsel_oe_o);
    endproperty
    a_devsel_release: assert property (p_devsel_release) // RL18
        else $error("device select floated without high drive");

    // The shared data lines are only taken during our own read
    property p_ad_owner;
        ad_oe_o |-> is_rd && devsel_oe_o && !devsel_n_o;
    endproperty
    a_ad_owner: assert property (p_ad_owner) // RL17
        else $error("address bus driven outside own read");

    property p_par_target;
        par_oe_o |-> is_rd;
    endproperty
    a_par_target: assert property (p_par_target) // RL10
        else $error("parity driven outside a read");

    property p_rd_hold;
        rd_req_o && !rd_valid_i |=> rd_req_o && $stable(rd_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) // RL14
        else $error("read request dropped before data arrived");

    // A stalled word must not change under the receiver
    property p_wr_hold;
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) // RL6
        else $error("write word changed while stalled");

    property p_perr_cause;
        perr_oe_o && !perr_n_o |-> $past(s_r.dp_chk && (s_r.dp_par != par_i));
    endproperty
    a_perr_cause: assert property (p_perr_cause) // RL21
        else $error("parity error reported without a bad write");

endmodule

`default_nettype wire

//--- verif/pbi_master.sv
`default_nettype none

// Bus master stand-in: one single-phase transaction at a time
module pbi_master
    import pbi_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic [31:0] ad_i,
    input  wire logic        trdy_n_i,
    output logic             frame_n_o,
    output logic             irdy_n_o,
    output logic      [31:0] ad_o,
    output logic             ad_oe_o,
    output logic      [3:0]  cbe_n_o,
    output logic             par_o,
    output logic             par_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic flip = 1'b0;
    logic p;
    logic e;

    // Idle: control lines parked high, nothing driven on the shared lines
    initial begin
        frame_n_o = 1'b1;
        irdy_n_o = 1'b1;
        ad_oe_o = 1'b0;
        cbe_n_o = 4'hF;
        par_oe_o = 1'b0;
    end

    // Parity lags the lines it covers by one clock; flip forces a fault
    always @(posedge clock_i) begin
        p = ^{ad_o, cbe_n_o} ^ flip;
        e = ad_oe_o;
        #1;
        par_o = p;
        par_oe_o = e;
    end

    // Address phase, then one data phase held until the target is ready;
    // gives up after 40 clocks so a missed decode cannot hang the bench
    task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] be, input logic [1:0] bad,
                        output logic [31:0] q, output int w);
        @(posedge clock_i);
        #1;
        frame_n_o = 1'b0;
        ad_o = a;
        ad_oe_o = 1'b1;
        cbe_n_o = c;
        flip = bad[0];
        @(posedge clock_i);
        #1;
        frame_n_o = 1'b1;
        irdy_n_o = 1'b0;
        ad_o = d;
        ad_oe_o = c[0];
        cbe_n_o = be;
        flip = bad[1];
        for (w = 0; w < 40; w++) begin
            @(posedge clock_i);
            if (trdy_n_i === 1'b0) break;
        end
        q = ad_i;
        #1;
        irdy_n_o = 1'b1;
        ad_oe_o = 1'b0;
        cbe_n_o = 4'hF;
        flip = 1'b0;
    endtask

endmodule

`default_nettype wire

//--- verif/pbi_target_test.sv
`default_nettype none

module pbi_target_test
    import pbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        clk_req_i = 1'b0;
    logic        sec_addr_perr_i = 1'b0;
    logic        rd_valid_i = 1'b0;
    logic [31:0] rd_data_i = '0;
    logic        wr_ready_i = 1'b0;
    logic        stall = 1'b0;
    logic        host_ckr = 1'b0;
    logic [31:0] junk = 32'h5A5A_A5A5;
    logic [31:0] ea, a, m_ad, ad_o, rd_addr_o;
    logic [3:0]  c, cbe_n_i;
    logic [1:0]  ts_q;
    logic        pchk = 1'b0;
    logic        d_q = 1'b0;
    logic        pexp, frame_n_i, irdy_n_i, m_oe, m_par, m_poe, ad_oe_o, par_o, par_oe_o;
    logic        trdy_n_o, trdy_oe_o, devsel_n_o, devsel_oe_o, perr_n_o, perr_oe_o;
    logic        serr_n_o, serr_oe_o, clkrun_n_o, clkrun_oe_o, clk_stop_o;
    logic        rd_req_o, wr_valid_o;
    pbi_wr_s     wr_data_o;
    pbi_wr_s     wq [$];
    logic [3:0]  cmds [4] = '{CMD_MEM_RD, CMD_MEM_WR, 4'h2, CMD_SPECIAL};
    int          err_count = 0;
    int          checked = 0;
    int          n_serr = 0;
    int          n_perr = 0;
    int          n_ck = 0;
    wire  [31:0] ad_i;
    wire         par_i, trdy, clkrun_n_i;

    // Shared lines: undriven data toggles, ready and clock-run are pulled up
    assign ad_i = ad_oe_o ? ad_o : m_oe ? m_ad : junk;
    assign par_i = par_oe_o ? par_o : m_poe ? m_par : junk[0];
    assign trdy = trdy_oe_o ? trdy_n_o : 1'b1;
    assign clkrun_n_i = host_ckr & (clkrun_oe_o ? clkrun_n_o : 1'b1);

    pbi_target dut (
        .clock_i, .nrst_i, .ad_i, .ad_o, .ad_oe_o, .cbe_n_i, .par_i, .par_o, .par_oe_o,
        .frame_n_i, .irdy_n_i, .trdy_n_o, .trdy_oe_o, .devsel_n_o, .devsel_oe_o,
        .perr_n_o, .perr_oe_o, .serr_n_o, .serr_oe_o, .clkrun_n_i, .clkrun_n_o,
        .clkrun_oe_o, .clk_stop_o, .clk_req_i, .sec_addr_perr_i, .rd_req_o, .rd_addr_o,
        .rd_valid_i, .rd_data_i, .wr_valid_o, .wr_data_o, .wr_ready_i
    );

    pbi_master m (
        .clock_i, .ad_i, .trdy_n_i(trdy), .frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i),
        .ad_o(m_ad), .ad_oe_o(m_oe), .cbe_n_o(cbe_n_i), .par_o(m_par), .par_oe_o(m_poe)
    );

    always #2 clock_i = ~clock_i;

    function automatic logic [31:0] rdf(input logic [31:0] x);
        return x ^ 32'h3C3C_0FF0;
    endfunction

    function automatic logic hit(input logic [3:0] k, input logic [31:0] x);
        return x[31:WIN_LSB] == WIN_BASE && (k == CMD_MEM_RD || k == CMD_MEM_WR);
    endfunction

    task automatic chk(input logic [67:0] s, input logic [67:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bus watch: ownership, release order, read parity and error pulses
    always @(posedge clock_i) begin
        junk <= ~junk;
        if (m_oe === 1'b1) chk(ad_oe_o, 1'b0);
        if (d_q && devsel_oe_o !== 1'b1) chk(ts_q, 2'b11);
        if (trdy === 1'b0) chk(devsel_n_o, 1'b0);
        if (pchk) chk({par_oe_o, par_i}, {1'b1, pexp});
        d_q = devsel_oe_o === 1'b1;
        ts_q = {trdy_n_o, devsel_n_o};
        pchk = ad_oe_o === 1'b1 && trdy === 1'b0 && irdy_n_i === 1'b0;
        pexp = ^{ad_i, cbe_n_i};
        n_serr += serr_oe_o === 1'b1;
        n_perr += perr_oe_o === 1'b1 && perr_n_o === 1'b0;
        n_ck += clkrun_n_i === 1'b0 && host_ckr;
    end

    // Local side: reads answered after a random delay, writes drained with stalls
    always @(posedge clock_i) begin
        if (wr_valid_o === 1'b1 && wr_ready_i) chk(wr_data_o, wq.pop_front());
        #1;
        rd_valid_i = rd_req_o === 1'b1 && !rd_valid_i && $urandom % 3 == 0;
        rd_data_i = rdf(rd_addr_o);
        if (rd_valid_i) chk(rd_addr_o, ea);
        wr_ready_i = !stall && $urandom % 2 == 1;
    end

    // One transaction, then its side effects once the bus has settled
    task automatic op(input logic [3:0] k, input logic [31:0] x, input logic [1:0] bad);
        logic [31:0] d;
        logic [31:0] q;
        logic [3:0]  be;
        int          w;
        int          s;
        int          p;
        d = $urandom;
        be = $urandom;
        s = n_serr;
        p = n_perr;
        if (hit(k, x) && k[0]) wq.push_back('{x, d, be});
        if (!k[0]) ea = x;
        m.xfer(k, x, d, be, bad, q, w);
        repeat (4) @(posedge clock_i);
        #1;
        chk(w < 40, hit(k, x));
        if (hit(k, x) && !k[0]) chk(q, rdf(x));
        chk(n_serr - s, bad[0]);
        chk(n_perr - p, bad[1] && hit(k, x) && k[0]);
    endtask

    // Reset held 16 clocks; outputs float and idle meanwhile
    task automatic rst();
        #1 nrst_i = 1'b0;
        repeat (16) @(posedge clock_i);
        chk({ad_oe_o, par_oe_o, trdy_oe_o, devsel_oe_o, perr_oe_o, serr_oe_o, clkrun_oe_o,
             rd_req_o, wr_valid_o, serr_n_o, trdy_n_o, devsel_n_o, perr_n_o, clkrun_n_o},
            14'h00F);
        #1 nrst_i = 1'b1;
    endtask

    initial begin
        repeat (30000) @(posedge clock_i);
        err_count++;
        results();
    end

    initial begin
        void'($urandom(1006));
        rst();
        @(posedge clock_i);
        // Two writes fill the buffer; the third must wait for the drain
        stall = 1'b1;
        op(CMD_MEM_WR, {WIN_BASE, 12'h000}, 2'b00);
        op(CMD_MEM_WR, {WIN_BASE, 12'hFFC}, 2'b00);
        fork
            op(CMD_MEM_WR, {WIN_BASE, 12'h010}, 2'b00);
            begin
                repeat (10) @(posedge clock_i);
                chk(trdy, 1'b1);
                stall = 1'b0;
            end
        join
        // Address and write-data parity faults, then one from the far side
        op(CMD_MEM_RD, {WIN_BASE, 12'h100}, 2'b01);
        op(CMD_MEM_WR, {WIN_BASE, 12'h104}, 2'b10);
        sec_addr_perr_i = 1'b1;
        n_serr = 0;
        @(posedge clock_i);
        #1 sec_addr_perr_i = 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk(n_serr, 1);
        // Clock released by the host with local demand: two low clocks
        host_ckr = 1'b1;
        clk_req_i = 1'b1;
        n_ck = 0;
        @(posedge clock_i);
        #1 clk_req_i = 1'b0;
        repeat (8) @(posedge clock_i);
        #1 chk(n_ck, 2);
        chk(clk_stop_o, 1'b1);
        // Stopped clock and a transaction in flight: the active state asks too
        n_ck = 0;
        op(CMD_MEM_WR, {WIN_BASE, 12'h200}, 2'b00);
        chk(n_ck, 2);
        host_ckr = 1'b0;
        // Random hits and misses over the four commands in cmds
        for (int i = 0; i < 40; i++) begin
            c = cmds[$urandom % 4];
            a = {WIN_BASE, 12'h000} | ($urandom & 32'h0000_0FFC);
            if ($urandom % 5 == 0) a[12] = 1'b1;
            op(c, a, 2'b00);
        end
        // Let posted writes drain so none is silently lost to the reset
        for (int i = 0; i < 50 && wq.size() > 0; i++) @(posedge clock_i);
        chk(wq.size(), 0);
        rst();
        op(CMD_MEM_RD, {WIN_BASE, 12'h008}, 2'b00);
        results();
    end

endmodule

`default_nettype wire
